// ---- iopc_top.sv ----
// port configuration block: ahb-lite registers, pin drive, pin interrupts
// assumes synchronous pin inputs and a nonvolatile strap held at release
`timescale 1ns/1ps
module iopc_top
    import iopc_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  ce,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [NPIN-1:0]       pin_in,
    input  wire logic                  nv_rst_pull_up,
    input  wire logic                  low_power,
    input  wire logic                  i2c_wake_match,
    output logic      [NPIN-1:0]       pad_out,
    output logic      [NPIN-1:0]       pad_oe,
    output logic      [NPIN*DM_W-1:0]  drive_mode,
    output logic      [NPIN-1:0]       pull_up_en,
    output logic      [NPIN-1:0]       pull_dn_en,
    output logic      [NPIN-1:0]       ibuf_en,
    output logic      [NPAIR*THR_W-1:0] thr_sel,
    output logic      [NPAIR-1:0]      diff_en,
    output logic      [NPAIR-1:0]      agl_ref_en,
    output logic      [NPAIR-1:0]      hyst_en,
    output logic                       lvttl_en,
    output logic                       irq,
    output logic                       wake
);
    iopc_boot_e               boot_q;
    iopc_aphase_s             ap_q;
    iopc_pair_cfg_s           cfg_q;
    logic                     wr_q;
    logic                     rst_pull_q;
    logic [NPIN*DM_W-1:0]     dm_q;
    logic [NPIN-1:0]          out_q;
    logic [NPIN-1:0]          ibuf_dis_q;
    logic [NPIN-1:0]          ibuf_en_q;
    logic [NPIN-1:0]          stat_q;
    logic [NPIN-1:0]          stat_d;
    logic [NPIN-1:0]          mask_q;
    logic [2*NPIN-1:0]        edge_q;
    logic [NPIN-1:0]          prev_q;
    logic [NPIN-1:0]          oe_q;
    logic [NPIN-1:0]          pu_q;
    logic [NPIN-1:0]          pd_q;
    logic [NPIN-1:0]          pin_vis;
    logic [NPIN-1:0]          evt;
    logic [31:0]              rd_d;
    logic [31:0]              rdata_q;
    logic                     irq_q;
    logic                     wake_q;
    logic                     ready_q;
    logic                     resp_q;
    logic                     ap_ok;
    logic                     ap_rd;
    logic                     wr_en;
    logic                     clr_stat;

    // address phase qualification, word transfers only
    assign ap_ok = hsel & hready & htrans[HTRANS_ACT_BIT]
                 & (hsize == HSIZE_WORD)
                 & (haddr[31:DEC_W] == '0);
    assign ap_rd = ap_ok & ~hwrite;
    assign wr_en = wr_q & ap_q.wr & ~low_power;
    assign clr_stat = ap_rd & (haddr[DEC_W-1:0] == OFS_INT_STAT);

    // capture the address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            ap_q   <= '0;
        end else if (ce) begin
            wr_q   <= ap_ok & hwrite;
            ap_q.wr  <= hwrite;
            ap_q.ofs <= haddr[DEC_W-1:0];
        end
    end

    // read data is muxed in the address phase and held for the data phase
    always_comb begin
        rd_d = '0;
        unique case (haddr[DEC_W-1:0])
            OFS_DATA_OUT: rd_d[NPIN-1:0] = out_q;
            OFS_DATA_IN:  rd_d[NPIN-1:0] = pin_vis;
            OFS_DRIVE:    rd_d[NPIN*DM_W-1:0] = dm_q;
            OFS_IBUF_DIS: rd_d[NPIN-1:0] = ibuf_dis_q;
            OFS_PAIR_CFG: rd_d[CFG_W-1:0] = cfg_q;
            OFS_RST_CFG:  rd_d[0] = rst_pull_q;
            OFS_INT_STAT: rd_d[NPIN-1:0] = stat_q;
            OFS_INT_MASK: rd_d[NPIN-1:0] = mask_q;
            OFS_INT_EDGE: rd_d[2*NPIN-1:0] = edge_q;
            default:      rd_d = '0;
        endcase
    end

    // bus answer flops, zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= '0;
            ready_q <= 1'b1;
            resp_q  <= HRESP_OKAY;
        end else if (ce) begin
            ready_q <= 1'b1;
            resp_q  <= HRESP_OKAY;
            if (ap_rd) begin
                rdata_q <= rd_d;
            end
        end
    end

    // boot sequencer and stored reset configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q     <= BOOT_LOAD;
            rst_pull_q <= 1'b0;
        end else if (ce && boot_q == BOOT_LOAD) begin
            rst_pull_q <= nv_rst_pull_up;
            boot_q     <= BOOT_RUN;
        end
    end

    // drive mode register, loaded from reset config then by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dm_q <= {NPIN{DM_HIZ_ANALOG}};
        end else if (ce) begin
            if (boot_q == BOOT_LOAD) begin
                dm_q <= nv_rst_pull_up ? {NPIN{DM_PULL_UP}}
                                       : {NPIN{DM_PULL_DN}};
            end else if (wr_en && ap_q.ofs == OFS_DRIVE) begin
                dm_q <= hwdata[NPIN*DM_W-1:0];
            end
        end
    end

    // output data and input buffer disables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q      <= '0;
            ibuf_dis_q <= '0;
            ibuf_en_q  <= '1;
        end else if (ce && wr_en) begin
            if (ap_q.ofs == OFS_DATA_OUT) begin
                out_q <= hwdata[NPIN-1:0];
            end
            if (ap_q.ofs == OFS_IBUF_DIS) begin
                ibuf_dis_q <= hwdata[NPIN-1:0];
                ibuf_en_q  <= ~hwdata[NPIN-1:0];
            end
        end
    end

    // special pin pair configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= '0;
        end else if (ce && wr_en && ap_q.ofs == OFS_PAIR_CFG) begin
            cfg_q <= hwdata[CFG_W-1:0];
        end
    end

    // interrupt mask and edge selection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= '0;
            edge_q <= '0;
        end else if (ce && wr_en) begin
            if (ap_q.ofs == OFS_INT_MASK) begin
                mask_q <= hwdata[NPIN-1:0];
            end
            if (ap_q.ofs == OFS_INT_EDGE) begin
                edge_q <= hwdata[2*NPIN-1:0];
            end
        end
    end

    // disabled buffers read and detect as low
    assign pin_vis = pin_in & ~ibuf_dis_q;
    // edge detection runs regardless of low power
    assign evt = (pin_vis & ~prev_q & edge_q[NPIN-1:0])
               | (~pin_vis & prev_q & edge_q[2*NPIN-1:NPIN]);
    // a new event wins over the read clear
    assign stat_d = (stat_q & ~{NPIN{clr_stat}}) | evt;

    // sticky status, interrupt and wake levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= '0;
            stat_q <= '0;
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce) begin
            prev_q <= pin_vis;
            stat_q <= stat_d;
            irq_q  <= |(stat_d & mask_q);
            wake_q <= low_power & ((|(stat_d & mask_q)) | i2c_wake_match);
        end
    end

    // pad enables and pulls from each pin's drive mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_q <= '0;
            pu_q <= '0;
            pd_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < NPIN; i++) begin
                unique case (dm_q[i*DM_W +: DM_W])
                    DM_HIZ_ANALOG, DM_HIZ_DIGITAL: begin
                        oe_q[i] <= 1'b0;
                        pu_q[i] <= 1'b0;
                        pd_q[i] <= 1'b0;
                    end
                    DM_PULL_UP: begin
                        oe_q[i] <= 1'b0;
                        pu_q[i] <= 1'b1;
                        pd_q[i] <= 1'b0;
                    end
                    DM_PULL_DN: begin
                        oe_q[i] <= 1'b0;
                        pu_q[i] <= 1'b0;
                        pd_q[i] <= 1'b1;
                    end
                    DM_OD_LOW: begin
                        oe_q[i] <= ~out_q[i];
                        pu_q[i] <= 1'b0;
                        pd_q[i] <= 1'b0;
                    end
                    DM_OD_HIGH: begin
                        oe_q[i] <= out_q[i];
                        pu_q[i] <= 1'b0;
                        pd_q[i] <= 1'b0;
                    end
                    DM_STRONG: begin
                        oe_q[i] <= 1'b1;
                        pu_q[i] <= 1'b0;
                        pd_q[i] <= 1'b0;
                    end
                    DM_PULL_BOTH: begin
                        oe_q[i] <= 1'b0;
                        pu_q[i] <= 1'b1;
                        pd_q[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // outputs, all straight from flops
    assign hrdata     = rdata_q;
    assign hreadyout  = ready_q;
    assign hresp      = resp_q;
    assign pad_out    = out_q;
    assign pad_oe     = oe_q;
    assign drive_mode = dm_q;
    assign pull_up_en = pu_q;
    assign pull_dn_en = pd_q;
    assign ibuf_en    = ibuf_en_q;
    assign thr_sel    = cfg_q.thr;
    assign diff_en    = cfg_q.diff;
    assign agl_ref_en = cfg_q.agl;
    assign hyst_en    = cfg_q.hyst;
    assign lvttl_en   = cfg_q.lvttl;
    assign irq        = irq_q;
    assign wake       = wake_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_reset_hiz: assert property (
        boot_q == BOOT_LOAD |-> dm_q == '0 && oe_q == '0)
        else $error("pins not high impedance before load");
    chk_nv_copy: assert property (
        boot_q == BOOT_LOAD && ce |=> boot_q == BOOT_RUN
            && rst_pull_q == $past(nv_rst_pull_up))
        else $error("reset config not copied at release");
    chk_port_pull: assert property (
        boot_q == BOOT_LOAD && ce ##1 ce |=>
            (pu_q == {NPIN{rst_pull_q}}) && (pd_q == ~pu_q))
        else $error("port pull not set from reset config");
    chk_sleep_hold: assert property (
        boot_q == BOOT_RUN && low_power ##1 low_power |->
            $stable(dm_q) && $stable(out_q) && $stable(cfg_q))
        else $error("pin state changed in low power");
    chk_sleep_event: assert property (
        ce && low_power && evt != '0 |=> (stat_q & $past(evt)) != '0)
        else $error("pin event lost in low power");
    chk_thr_write: assert property (
        ce && wr_en && ap_q.ofs == OFS_PAIR_CFG |=>
            thr_sel == $past(hwdata[NPAIR*THR_W-1:0]))
        else $error("threshold field not written");
    chk_default_se: assert property (
        boot_q == BOOT_LOAD |-> diff_en == '0 && agl_ref_en == '0)
        else $error("special pins not single ended at reset");
    chk_wake_match: assert property (
        ce && low_power && i2c_wake_match |=> wake)
        else $error("address match did not wake");
    chk_ibuf_read: assert property (
        ce && ap_rd && haddr[DEC_W-1:0] == OFS_DATA_IN |=>
            (hrdata[NPIN-1:0] & $past(ibuf_dis_q)) == '0)
        else $error("disabled buffer read high");
    chk_thr_reset: assert property (
        boot_q == BOOT_LOAD |-> thr_sel == '0)
        else $error("threshold code not zero at reset");
    chk_irq_level: assert property (
        ce && (stat_d & mask_q) != '0 |=> irq ##0 stat_q != '0)
        else $error("interrupt not raised");
endmodule

// ---- iopc_pkg.sv ----
// constants, types and register map of the port configuration block
// assumes one eight pin port of four special pin pairs on ahb-lite
package iopc_pkg;
    localparam int NPIN   = 8;
    localparam int NPAIR  = 4;
    localparam int DM_W   = 3;
    localparam int THR_W  = 2;
    localparam int DEC_W  = 8;
    // register byte offsets
    localparam logic [7:0] OFS_DATA_OUT = 8'h00;
    localparam logic [7:0] OFS_DATA_IN  = 8'h04;
    localparam logic [7:0] OFS_DRIVE    = 8'h08;
    localparam logic [7:0] OFS_IBUF_DIS = 8'h0c;
    localparam logic [7:0] OFS_PAIR_CFG = 8'h10;
    localparam logic [7:0] OFS_RST_CFG  = 8'h14;
    localparam logic [7:0] OFS_INT_STAT = 8'h18;
    localparam logic [7:0] OFS_INT_MASK = 8'h1c;
    localparam logic [7:0] OFS_INT_EDGE = 8'h20;
    // drive modes
    localparam logic [2:0] DM_HIZ_ANALOG  = 3'h0;
    localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
    localparam logic [2:0] DM_PULL_UP     = 3'h2;
    localparam logic [2:0] DM_PULL_DN     = 3'h3;
    localparam logic [2:0] DM_OD_LOW      = 3'h4;
    localparam logic [2:0] DM_OD_HIGH     = 3'h5;
    localparam logic [2:0] DM_STRONG      = 3'h6;
    localparam logic [2:0] DM_PULL_BOTH   = 3'h7;
    // threshold codes in listed order
    localparam logic [1:0] THR_HALF_SUPPLY = 2'h0;
    localparam logic [1:0] THR_FRAC_SUPPLY = 2'h1;
    localparam logic [1:0] THR_HALF_REF    = 2'h2;
    localparam logic [1:0] THR_FULL_REF    = 2'h3;
    // ahb encodings
    localparam int         HTRANS_ACT_BIT = 1;
    localparam logic [2:0] HSIZE_WORD     = 3'h2;
    localparam logic       HRESP_OKAY     = 1'b0;
    // special pin configuration word, bit 0 upward: thr, diff, agl, hyst, lvttl
    typedef struct packed {
        logic                   lvttl;
        logic [NPAIR-1:0]       hyst;
        logic [NPAIR-1:0]       agl;
        logic [NPAIR-1:0]       diff;
        logic [NPAIR*THR_W-1:0] thr;
    } iopc_pair_cfg_s;
    localparam int CFG_W = $bits(iopc_pair_cfg_s);
    // captured address phase
    typedef struct packed {
        logic       wr;
        logic [7:0] ofs;
    } iopc_aphase_s;
    typedef enum logic {
        BOOT_LOAD = 1'b0,
        BOOT_RUN  = 1'b1
    } iopc_boot_e;
endpackage

// ---- iopc_pin_model.sv ----
// far side model: the circuits hanging on the eight port pins
// assumes flop outputs of the port block and bench-driven external drivers
`timescale 1ns/1ps
module iopc_pin_model
    import iopc_pkg::*;
(
    input  wire logic            hclk,
    input  wire logic [NPIN-1:0] pad_out,
    input  wire logic [NPIN-1:0] pad_oe,
    input  wire logic [NPIN-1:0] pull_up_en,
    input  wire logic [NPIN-1:0] pull_dn_en,
    input  wire logic [NPIN-1:0] ext_val,
    input  wire logic [NPIN-1:0] ext_en,
    output logic      [NPIN-1:0] pin_in
);
    logic [NPIN-1:0] last_q = '0;
    logic [NPIN-1:0] drv;
    logic [NPIN-1:0] lvl;
    // pad wins over the external driver, which wins over the pulls
    assign drv = pad_oe | ext_en | pull_up_en | pull_dn_en;
    assign lvl = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
               | (~pad_oe & ~ext_en & pull_up_en);
    // an undriven pin shows the inverse of its last driven level
    assign pin_in = (drv & lvl) | (~drv & ~last_q);
    // remembers the last driven level, frozen while the pin floats
    always_ff @(posedge hclk) begin
        last_q <= (drv & lvl) | (~drv & last_q);
    end
endmodule

// ---- tb_io_port_reset_threshold_config.sv ----
// bench for the port configuration block: ahb-lite tasks and sequences
// assumes one ahb slave, so hready is the block's own hreadyout
`timescale 1ns/1ps
module tb_io_port_reset_threshold_config
    import iopc_pkg::*;
;
    logic hclk, hresetn, ce, hsel, hwrite, nv, low_power, i2c;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hready, hreadyout, hresp, irq, wake, lvttl_en;
    logic [NPIN-1:0] pin_in, pad_out, pad_oe, pu, pd, ibuf_en, ev, ee;
    logic [NPIN*DM_W-1:0] drive_mode;
    logic [NPAIR*THR_W-1:0] thr_sel;
    logic [NPAIR-1:0] diff_en, agl_ref_en, hyst_en;
    int errors, n_tests;
    assign hready = hreadyout;
    iopc_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
        .nv_rst_pull_up(nv), .low_power(low_power),
        .i2c_wake_match(i2c), .pad_out(pad_out), .pad_oe(pad_oe),
        .drive_mode(drive_mode), .pull_up_en(pu), .pull_dn_en(pd),
        .ibuf_en(ibuf_en), .thr_sel(thr_sel), .diff_en(diff_en),
        .agl_ref_en(agl_ref_en), .hyst_en(hyst_en), .lvttl_en(lvttl_en),
        .irq(irq), .wake(wake));
    iopc_pin_model pins (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_up_en(pu), .pull_dn_en(pd), .ext_val(ev), .ext_en(ee),
        .pin_in(pin_in));
    // clock of 8 ns
    always #4 hclk = ~hclk;
    // verdict and end of run
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask
    // waits for an edge where flag sel is high: 0 ready, 1 irq, 2 wake
    task automatic wait_hi(input string nm, input int sel);
        int k;
        logic f;
        k = 0;
        f = 1'b0;
        while (f !== 1'b1 && k < 40) begin
            @(posedge hclk);
            k++;
            f = (sel == 0) ? hready : ((sel == 1) ? irq : wake);
        end
        if (f !== 1'b1) begin
            chk(nm, 32'h1, 32'h0);
            report_and_stop();
        end
    endtask
    // one single ahb transfer; read data taken at the data phase edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        haddr <= {24'h0, a};
        wait_hi("addr phase", 0);
        htrans <= 2'h0;
        hwdata <= d;
        wait_hi("data phase", 0);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd);
        repeat (3) @(posedge hclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        xfer(1'b0, a, 32'h0, rd);
        chk(nm, e, rd);
    endtask
    task automatic do_reset(input logic strap);
        hresetn <= 1'b0;
        nv <= strap;
        repeat (16) @(posedge hclk);
        chk("rst drive", 24'h0, drive_mode);
        chk("rst oe", 8'h0, pad_oe);
        chk("rst pulls", 16'h0, {pu, pd});
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("boot drive", {NPIN{strap ? DM_PULL_UP : DM_PULL_DN}},
            drive_mode);
        chk("boot pulls", {{NPIN{strap}}, {NPIN{~strap}}}, {pu, pd});
        rdchk("rst cfg", OFS_RST_CFG, {31'h0, strap});
    endtask
    initial begin
        hclk = 1'b0; hresetn = 1'b0; ce = 1'b1; hsel = 1'b0;
        haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = HSIZE_WORD;
        hwdata = 32'h0; nv = 1'b1; low_power = 1'b0; i2c = 1'b0;
        ev = 8'h0; ee = 8'h0; errors = 0; n_tests = 0;
        do_reset(1'b1);
        do_reset(1'b0);
        rdchk("cfg reset", OFS_PAIR_CFG, 32'h0);
        chk("single ended", 4'h0, diff_en);
        // every threshold code on every pair, then a mixed pattern
        for (int c = 0; c < 4; c++) begin
            wr(OFS_PAIR_CFG, {24'h0, {NPAIR{c[1:0]}}});
            chk("thr code", {NPAIR{c[1:0]}}, thr_sel);
        end
        wr(OFS_PAIR_CFG, 32'h1a5c1b);
        chk("thr pairs", 8'h1b, thr_sel);
        chk("diff", 4'hc, diff_en);
        chk("agl", 4'h5, agl_ref_en);
        chk("hyst", 4'ha, hyst_en);
        chk("lvttl", 1'b1, lvttl_en);
        rdchk("cfg read", OFS_PAIR_CFG, 32'h1a5c1b);
        ee <= 8'hff;
        ev <= 8'h5a;
        wr(OFS_IBUF_DIS, 32'hff);
        chk("ibuf off", 8'h0, ibuf_en);
        rdchk("in masked", OFS_DATA_IN, 32'h0);
        wr(OFS_IBUF_DIS, 32'h0f);
        rdchk("in part", OFS_DATA_IN, 32'h50);
        rdchk("unmapped", 8'h40, 32'h0);
        ev <= 8'h0;
        // every pin in open drain low mode, output data low
        wr(OFS_DRIVE, {8'h0, {NPIN{DM_OD_LOW}}});
        chk("od low oe", 8'hff, pad_oe);
        // pin i in mode i, output data low then high
        wr(OFS_DRIVE, 32'hfac688);
        chk("mode oe", 8'h50, pad_oe);
        chk("mode pulls", 16'h8488, {pu, pd});
        wr(OFS_DATA_OUT, 32'hff);
        chk("out oe", 8'h60, pad_oe);
        chk("pad out", 8'hff, pad_out);
        rdchk("out reg", OFS_DATA_OUT, 32'hff);
        wr(OFS_DRIVE, {8'h0, {NPIN{DM_HIZ_DIGITAL}}});
        chk("hiz oe", 8'h0, pad_oe);
        ee <= 8'hff;
        wr(OFS_IBUF_DIS, 32'h0);
        wr(OFS_INT_EDGE, 32'h03);
        wr(OFS_INT_MASK, 32'h01);
        rdchk("stat clear", OFS_INT_STAT, 32'h0);
        ev <= 8'h01;
        wait_hi("irq rise", 1);
        rdchk("stat set", OFS_INT_STAT, 32'h01);
        repeat (2) @(posedge hclk);
        chk("irq cleared", 1'b0, irq);
        rdchk("stat read clr", OFS_INT_STAT, 32'h0);
        ev <= 8'h03;
        repeat (4) @(posedge hclk);
        chk("masked irq", 1'b0, irq);
        rdchk("masked stat", OFS_INT_STAT, 32'h02);
        // a frozen block takes no bus write
        ce <= 1'b0;
        wr(OFS_INT_MASK, 32'h03);
        ce <= 1'b1;
        rdchk("frozen mask", OFS_INT_MASK, 32'h01);
        // low power: writes dropped, events still wake the part
        ev <= 8'h0;
        low_power <= 1'b1;
        wr(OFS_DRIVE, 32'h0);
        chk("lp drive", {NPIN{DM_HIZ_DIGITAL}}, drive_mode);
        rdchk("lp drive reg", OFS_DRIVE, {8'h0, {NPIN{DM_HIZ_DIGITAL}}});
        ev <= 8'h01;
        wait_hi("pin wake", 2);
        rdchk("lp stat", OFS_INT_STAT, 32'h01);
        repeat (2) @(posedge hclk);
        chk("wake drop", 1'b0, wake);
        i2c <= 1'b1;
        wait_hi("bus wake", 2);
        low_power <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("awake", 1'b0, wake);
        chk("okay", 1'b0, hresp);
        chk("ready", 1'b1, hreadyout);
        report_and_stop();
    end
endmodule
